// *** verilog/swrd_top.sv ***
// Route tables, node identifier, debug pin and link status registers behind AHB-Lite.
// Assumes a single AHB-Lite master, whole-word transfers, and fabric inputs on clk.
`timescale 1ns/1ps
module swrd_top
	import swrd_pkg::*;
#(
	parameter int NEXT = NUM_EXT,
	parameter int NPL  = NUM_PLINK
)(
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	// AHB-Lite slave
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic      [31:0]              hrdata,
	// Route lookup
	input  wire logic                     routeReq,
	input  wire logic [ID_W-1:0]          routeDestId,
	output logic                          routeDone,
	output logic      [DIR_W-1:0]         routeDir,
	output logic                          routeLocal,
	// Link fabric status, external links first then processor links
	input  wire logic [NEXT+NPL-1:0]      linkInRoute,
	input  wire logic [NEXT+NPL-1:0]      linkOutRoute,
	input  wire logic [NEXT+NPL-1:0]      linkJunk,
	input  wire logic [(NEXT+NPL)*2-1:0]  linkDstType,
	input  wire logic [(NEXT+NPL)*8-1:0]  linkDstNum,
	output logic      [NEXT*DIR_W-1:0]    linkDirection,
	output logic      [(NEXT+NPL)*2-1:0]  linkNetwork,
	// Debug
	input  wire logic                     nodeInDebug,
	input  wire logic                     tileDebugReq,
	input  wire logic                     debugPinIn,
	output logic                          debugPinOut,
	output logic                          debugPinOe_n,
	output logic                          debugCallTrap,
	// Interrupt
	output logic                          irq
);
	localparam int NL = NEXT + NPL;

	typedef struct packed {
		logic [ID_W-1:0]       nodeId;
		logic [31:0]           dirLow;
		logic [31:0]           dirHigh;
		logic [1:0]            dbgCfg;
		logic [NEXT*DIR_W-1:0] extDir;
		logic [NL*NET_W-1:0]   net;
		logic [IRQ_W-1:0]      irqStat;
		logic [IRQ_W-1:0]      irqMask;
		logic                  irq;
		logic                  ready;
		logic [31:0]           rdata;
		logic                  rdPend;
		logic                  wrPend;
		logic                  idxOk;
		logic [7:0]            idx;
		logic                  routeDone;
		logic [DIR_W-1:0]      routeDir;
		logic                  routeLocal;
		logic [NL-1:0]         junkPrev;
	} swrd_state_t;

	swrd_state_t st_q;
	swrd_state_t st_d;

	logic             addrPhase;
	logic [DIR_W-1:0] lookDir;
	logic             lookLocal;
	logic             srcWrEn;
	logic             srcPin;
	logic             srcTile;
	logic             pinEvent;
	logic             tileEvent;
	logic [31:0]      rdWord;
	logic [31:0]      linkWord [NL];
	logic [DIR_W-1:0] dirField [NL];
	logic             wrLive;
	logic             rdLive;

	// Status word per link; type and number only mean something while routing inward
	genvar k;
	generate
		for (k = 0; k < NL; k++) begin : g_link
			// Processor links carry no direction field
			if (k < NEXT) begin : g_dir
				assign dirField[k] = st_q.extDir[k*DIR_W +: DIR_W];
			end else begin : g_nodir
				assign dirField[k] = '0;
			end
			always_comb begin
				linkWord[k] = WORD_RST;
				if (linkInRoute[k]) begin
					linkWord[k][ST_TYPE_LSB +: DTYPE_W] = linkDstType[k*DTYPE_W +: DTYPE_W];
					linkWord[k][ST_NUM_LSB +: DNUM_W] = linkDstNum[k*DNUM_W +: DNUM_W];
				end
				linkWord[k][ST_DIR_LSB +: DIR_W] = dirField[k];
				linkWord[k][ST_NET_LSB +: NET_W] = st_q.net[k*NET_W +: NET_W];
				linkWord[k][ST_JUNK_BIT] = linkJunk[k];
				linkWord[k][ST_OUT_BIT] = linkOutRoute[k];
				linkWord[k][ST_IN_BIT] = linkInRoute[k];
			end
		end
	endgenerate

	swrd_route swrd_route_inst (
		.nodeId    (st_q.nodeId),
		.destId    (routeDestId),
		.dirLow    (st_q.dirLow),
		.dirHigh   (st_q.dirHigh),
		.direction (lookDir),
		.isLocal   (lookLocal)
	);

	assign srcWrEn = st_q.wrPend && st_q.idxOk && (st_q.idx == IDX_DBG_SRC);

	swrd_debug swrd_debug_inst (
		.clk           (clk),
		.reset_n       (reset_n),
		.cfgDrive      (st_q.dbgCfg[DBG_DRIVE_BIT]),
		.cfgCall       (st_q.dbgCfg[DBG_CALL_BIT]),
		.nodeInDebug   (nodeInDebug),
		.tileDebugReq  (tileDebugReq),
		.debugCallTrap (debugCallTrap),
		.debugPinIn    (debugPinIn),
		.debugPinOut   (debugPinOut),
		.debugPinOe_n  (debugPinOe_n),
		.srcWrEn       (srcWrEn),
		.srcWrPin      (hwdata[SRC_PIN_BIT]),
		.srcWrTile     (hwdata[SRC_TILE_BIT]),
		.srcPin        (srcPin),
		.srcTile       (srcTile),
		.pinEvent      (pinEvent),
		.tileEvent     (tileEvent)
	);

	// Read mux over the registered index; unmapped reads return zero
	always_comb begin
		rdWord = WORD_RST;
		if (st_q.idxOk) begin
			case (st_q.idx)
				IDX_NODE_ID: rdWord[ID_W-1:0] = st_q.nodeId;
				IDX_DIR_LO: rdWord = st_q.dirLow;
				IDX_DIR_HI: rdWord = st_q.dirHigh;
				IDX_DBG_CFG: rdWord[1:0] = st_q.dbgCfg;
				IDX_IRQ_STAT: rdWord[IRQ_W-1:0] = st_q.irqStat;
				IDX_IRQ_MASK: rdWord[IRQ_W-1:0] = st_q.irqMask;
				IDX_DBG_SRC: begin
					rdWord[SRC_PIN_BIT] = srcPin;
					rdWord[SRC_TILE_BIT] = srcTile;
				end
				default: begin
					for (int i = 0; i < NEXT; i++) begin
						if (st_q.idx == IDX_EXT_BASE + 8'(i)) begin
							rdWord = linkWord[i];
						end
					end
					for (int j = 0; j < NPL; j++) begin
						if (st_q.idx == IDX_PL_BASE + 8'(j)) begin
							rdWord = linkWord[NEXT+j];
						end
					end
				end
			endcase
		end
	end

	always_comb begin
		st_d = st_q;
		addrPhase = hsel && (htrans == HTRANS_NONSEQ) && hready;

		// Write data phase
		if (st_q.wrPend && st_q.idxOk) begin
			case (st_q.idx)
				IDX_NODE_ID: st_d.nodeId = hwdata[ID_W-1:0];
				IDX_DIR_LO: st_d.dirLow = hwdata;
				IDX_DIR_HI: st_d.dirHigh = hwdata;
				IDX_DBG_CFG: st_d.dbgCfg = hwdata[1:0];
				IDX_IRQ_STAT: st_d.irqStat = st_q.irqStat & ~hwdata[IRQ_W-1:0];
				IDX_IRQ_MASK: st_d.irqMask = hwdata[IRQ_W-1:0];
				default: begin
					for (int i = 0; i < NEXT; i++) begin
						if (st_q.idx == IDX_EXT_BASE + 8'(i)) begin
							st_d.extDir[i*DIR_W +: DIR_W] = hwdata[ST_DIR_LSB +: DIR_W];
							st_d.net[i*NET_W +: NET_W] = hwdata[ST_NET_LSB +: NET_W];
						end
					end
					for (int j = 0; j < NPL; j++) begin
						if (st_q.idx == IDX_PL_BASE + 8'(j)) begin
							st_d.net[(NEXT+j)*NET_W +: NET_W] = hwdata[ST_NET_LSB +: NET_W];
						end
					end
				end
			endcase
		end

		// Reads take one wait state so the data always reflects any write just before
		st_d.wrPend = addrPhase && hwrite;
		st_d.rdPend = addrPhase && !hwrite;
		st_d.ready = !(addrPhase && !hwrite);
		if (addrPhase) begin
			st_d.idx = haddr[IDX_MSB:IDX_LSB];
			st_d.idxOk = (haddr[31:IDX_MSB+1] == '0);
		end
		if (st_q.rdPend) begin
			st_d.rdata = rdWord;
		end

		// Sticky events; a set in the clearing cycle survives
		st_d.junkPrev = linkJunk;
		st_d.irqStat[IRQ_PIN_BIT] = st_d.irqStat[IRQ_PIN_BIT] | pinEvent;
		st_d.irqStat[IRQ_TILE_BIT] = st_d.irqStat[IRQ_TILE_BIT] | tileEvent;
		st_d.irqStat[IRQ_JUNK_BIT] = st_d.irqStat[IRQ_JUNK_BIT] | (|(linkJunk & ~st_q.junkPrev));
		st_d.irq = |(st_d.irqStat & st_d.irqMask);

		// Route lookup uses the tables as they stand this cycle
		st_d.routeDone = routeReq;
		if (routeReq) begin
			st_d.routeDir = lookLocal ? '0 : lookDir;
			st_d.routeLocal = lookLocal;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '{ready: 1'b1, rdata: WORD_RST, dirLow: WORD_RST, dirHigh: WORD_RST,
				default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	assign hreadyout = st_q.ready;
	assign hresp = 1'b0;
	assign hrdata = st_q.rdata;
	assign routeDone = st_q.routeDone;
	assign routeDir = st_q.routeDir;
	assign routeLocal = st_q.routeLocal;
	assign linkDirection = st_q.extDir;
	assign linkNetwork = st_q.net;
	assign irq = st_q.irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	route_upper_a: assert property (routeReq && routeDestId[15] != st_q.nodeId[15]
		|=> routeDir == $past(st_q.dirHigh[31:28]))
		else $error("top mismatch bit not routed by upper table top field");
	route_low8_a: assert property (routeReq && routeDestId[15:1] == st_q.nodeId[15:1]
		&& routeDestId[0] != st_q.nodeId[0] |=> routeDir == $past(st_q.dirLow[3:0]))
		else $error("bit 0 mismatch not routed by lowest field");
	route_bit8_a: assert property (routeReq && routeDestId[15:9] == st_q.nodeId[15:9]
		&& routeDestId[8] != st_q.nodeId[8] |=> routeDir == $past(st_q.dirHigh[3:0]))
		else $error("bit 8 mismatch not routed by upper table low field");
	route_lower_a: assert property (routeReq && routeDestId[15:8] == st_q.nodeId[15:8]
		&& routeDestId[7] != st_q.nodeId[7] |=> routeDir == $past(st_q.dirLow[31:28]))
		else $error("bit 7 mismatch not routed by lower table");
	route_local_a: assert property (routeReq && routeDestId == st_q.nodeId
		|=> routeDone && routeLocal)
		else $error("matching destination not delivered locally");
	node_write_a: assert property (st_q.wrPend && st_q.idxOk && st_q.idx == IDX_NODE_ID
		|=> st_q.nodeId == $past(hwdata[ID_W-1:0]))
		else $error("node identifier write lost");
	ext_dir_a: assert property (st_q.wrPend && st_q.idxOk && st_q.idx == IDX_EXT_BASE
		|=> linkDirection[DIR_W-1:0] == $past(hwdata[ST_DIR_LSB +: DIR_W]))
		else $error("link direction write lost");
	read_wait_a: assert property (addrPhase && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read did not take exactly one wait state");
	junk_read_a: assert property (rdLive && st_q.idx == IDX_EXT_BASE + 8'h04
		|=> hrdata[ST_JUNK_BIT] == $past(linkJunk[4]))
		else $error("junk bit not reported");
	irq_level_a: assert property (irq == |(st_q.irqStat & st_q.irqMask))
		else $error("interrupt level disagrees with status and mask");

	// Data-phase qualifiers for the checks below
	assign wrLive = st_q.wrPend && st_q.idxOk;
	assign rdLive = st_q.rdPend && st_q.idxOk;

	// Register writes land one edge after their data phase
	cfg_write_a: assert property (wrLive && st_q.idx == IDX_DBG_CFG
		|=> st_q.dbgCfg == $past(hwdata[1:0]))
		else $error("config write lost");
	dir_high_a: assert property (wrLive && st_q.idx == IDX_DIR_HI
		|=> st_q.dirHigh == $past(hwdata))
		else $error("upper table write lost");
	dir_low_a: assert property (wrLive && st_q.idx == IDX_DIR_LO
		|=> st_q.dirLow == $past(hwdata))
		else $error("lower table write lost");
	ext_net_a: assert property (wrLive && st_q.idx == IDX_EXT_BASE
		|=> linkNetwork[NET_W-1:0] == $past(hwdata[ST_NET_LSB +: NET_W]))
		else $error("link network write lost");
	pl_net_a: assert property (wrLive && st_q.idx == IDX_PL_BASE
		|=> linkNetwork[NEXT*NET_W +: NET_W] == $past(hwdata[ST_NET_LSB +: NET_W]))
		else $error("plink network write lost");
	write_nowait_a: assert property (addrPhase && hwrite |=> hreadyout)
		else $error("write got a wait state");

	// Readback of status words and reserved bits
	in_out_a: assert property (rdLive && st_q.idx == IDX_EXT_BASE + 8'h03
		|=> hrdata[ST_OUT_BIT:ST_IN_BIT] == $past({linkOutRoute[3], linkInRoute[3]}))
		else $error("route bits not reported");
	dst_num_a: assert property (rdLive && st_q.idx == IDX_EXT_BASE + 8'h03
		&& linkInRoute[3] |=> hrdata[ST_NUM_LSB +: DNUM_W] == $past(linkDstNum[31:24]))
		else $error("destination number not reported");
	dst_idle_a: assert property (rdLive && st_q.idx == IDX_EXT_BASE
		&& !linkInRoute[0] |=> hrdata[31:ST_NUM_LSB] == '0)
		else $error("type or number shown while idle");
	pl_rsvd_a: assert property (rdLive && st_q.idx == IDX_PL_BASE
		|=> hrdata[15:ST_NET_LSB+NET_W] == '0)
		else $error("plink reserved bits set");
	src_rsvd_a: assert property (rdLive && st_q.idx == IDX_DBG_SRC
		|=> hrdata[31:SRC_PIN_BIT+1] == '0 && hrdata[SRC_PIN_BIT-1:SRC_TILE_BIT+1] == '0)
		else $error("source reserved bits set");
	cfg_rsvd_a: assert property (rdLive && st_q.idx == IDX_DBG_CFG
		|=> hrdata[31:DBG_CALL_BIT+1] == '0)
		else $error("config reserved bits set");
	node_rsvd_a: assert property (rdLive && st_q.idx == IDX_NODE_ID
		|=> hrdata[31:ID_W] == '0)
		else $error("node id reserved bits set");

	// Junk start is a sticky event
	junk_set_a: assert property (|(linkJunk & ~st_q.junkPrev)
		|=> st_q.irqStat[IRQ_JUNK_BIT])
		else $error("junk start not latched");

	route_far_c: cover property (routeReq ##1 routeDone && !routeLocal);
	read_ext_c: cover property (st_q.rdPend && st_q.idx == IDX_EXT_BASE);
	irq_rise_c: cover property (!irq ##1 irq);
	dbg_call_c: cover property (debugCallTrap);
	pl_read_c: cover property (rdLive && st_q.idx == IDX_PL_BASE);
endmodule

// *** verilog/swrd_pkg.sv ***
// Constants for the route, debug-pin and link-status configuration block.
// Assumes one switch clock and an AHB-Lite master that issues whole-word single transfers.
// Summary of operation
// - Upper table holds eight directions for first mismatch in identifier bits 15..8.
// - Packet routes by direction of most significant bit differing from node identifier.
// - Upper directions are 4-bit RW, reset 0; 31:28 for bit 15 down to 3:0.
// - With debug-call enable bit 1 set, debug pin activity raises a core debug call.
// - With bit 0 set, debug pin is pulled low while node is in debug mode.
// - Debug source bit 4 marks the pin as cause of the latest debug interrupt.
// - Debug source bit 0 marks the tile as cause; other bits reserved, read zero.
// - Eight external link status registers at 0x20..0x27, links C,D,B,A,G,H,E,F.
// - Bits 25:24 show destination link type while link routes into the switch.
// - Bits 23:16 show destination link number while routing inward; reset zero.
// - Bits 11:8 hold the link's direction, written by software, used for routing.
// - Bits 5:4 select link network for quality of service on every link; reset zero.
// - Bit 2 reads one while the current packet is discarded as junk.
// - Bit 1 reads one while switch sends data out over a route from another link.
// - Bit 0 reads one while link feeds the switch with a route established.
// - Processor link registers 0x40..0x43 share the fields except direction; 15:6 reserved.
// - Node holds a 16-bit RW identifier, reset zero, compared MSB first.
// - Lower table supplies eight directions for first mismatch in identifier bits 7..0.
package swrd_pkg;
	localparam int NUM_EXT    = 8;
	localparam int NUM_PLINK  = 4;
	localparam int DIR_W      = 4;
	localparam int NET_W      = 2;
	localparam int ID_W       = 16;
	localparam int DTYPE_W    = 2;
	localparam int DNUM_W     = 8;
	localparam int IDX_LSB    = 2;
	localparam int IDX_MSB    = 9;
	localparam int IRQ_W      = 3;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_NODE_ID  = 8'h05;
	localparam logic [7:0] IDX_DIR_LO   = 8'h0C;
	localparam logic [7:0] IDX_DIR_HI   = 8'h0D;
	localparam logic [7:0] IDX_DBG_CFG  = 8'h10;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h11;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h12;
	localparam logic [7:0] IDX_DBG_SRC  = 8'h1F;
	localparam logic [7:0] IDX_EXT_BASE = 8'h20;
	localparam logic [7:0] IDX_PL_BASE  = 8'h40;
	// Link status field positions
	localparam int ST_TYPE_LSB = 24;
	localparam int ST_NUM_LSB  = 16;
	localparam int ST_DIR_LSB  = 8;
	localparam int ST_NET_LSB  = 4;
	localparam int ST_JUNK_BIT = 2;
	localparam int ST_OUT_BIT  = 1;
	localparam int ST_IN_BIT   = 0;
	// Debug configuration and source bits
	localparam int DBG_DRIVE_BIT = 0;
	localparam int DBG_CALL_BIT  = 1;
	localparam int SRC_TILE_BIT  = 0;
	localparam int SRC_PIN_BIT   = 4;
	// Interrupt status bits
	localparam int IRQ_PIN_BIT  = 0;
	localparam int IRQ_TILE_BIT = 1;
	localparam int IRQ_JUNK_BIT = 2;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage

// *** verilog/swrd_route.sv ***
// Most-significant-mismatch direction lookup, purely combinational.
// Assumes the caller registers the result.
`timescale 1ns/1ps
module swrd_route
	import swrd_pkg::*;
(
	// Identifiers
	input  wire logic [ID_W-1:0]     nodeId,
	input  wire logic [ID_W-1:0]     destId,
	// Direction tables
	input  wire logic [31:0]         dirLow,
	input  wire logic [31:0]         dirHigh,
	// Result
	output logic      [DIR_W-1:0]    direction,
	output logic                     isLocal
);
	logic [ID_W-1:0]  mismatch;
	logic [DIR_W-1:0] dirOf [ID_W];

	assign mismatch = nodeId ^ destId;

	genvar b;
	generate
		for (b = 0; b < ID_W; b++) begin : g_bit
			if (b >= 8) begin : g_hi
				assign dirOf[b] = dirHigh[(b-8)*DIR_W +: DIR_W];
			end else begin : g_lo
				assign dirOf[b] = dirLow[b*DIR_W +: DIR_W];
			end
		end
	endgenerate

	// Later (higher) bits override, so the top mismatch wins
	always_comb begin
		direction = '0;
		for (int i = 0; i < ID_W; i++) begin
			if (mismatch[i]) begin
				direction = dirOf[i];
			end
		end
		isLocal = (mismatch == '0);
	end
endmodule

// *** verilog/swrd_debug.sv ***
// Debug request pin control and debug source tracking.
// Assumes the pin level is synchronous to clk; the board pulls the wire high.
`timescale 1ns/1ps
module swrd_debug
	import swrd_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Configuration
	input  wire logic cfgDrive,
	input  wire logic cfgCall,
	// Node side
	input  wire logic nodeInDebug,
	input  wire logic tileDebugReq,
	output logic      debugCallTrap,
	// Open-drain pin
	input  wire logic debugPinIn,
	output logic      debugPinOut,
	output logic      debugPinOe_n,
	// Source register access
	input  wire logic srcWrEn,
	input  wire logic srcWrPin,
	input  wire logic srcWrTile,
	output logic      srcPin,
	output logic      srcTile,
	// Event pulses
	output logic      pinEvent,
	output logic      tileEvent
);
	typedef struct packed {
		logic pinPrev;
		logic callTrap;
		logic oe_n;
		logic srcPin;
		logic srcTile;
		logic pinEvt;
		logic tileEvt;
	} swrd_dbg_t;

	swrd_dbg_t st_q;
	swrd_dbg_t st_d;
	logic      pinFall;

	always_comb begin
		st_d = st_q;
		// Own pull-down must not re-trigger a call on this node
		pinFall = st_q.pinPrev && !debugPinIn && st_q.oe_n;
		st_d.pinPrev = debugPinIn;
		st_d.pinEvt = pinFall && cfgCall;
		st_d.callTrap = pinFall && cfgCall;
		st_d.tileEvt = tileDebugReq;
		st_d.oe_n = !(cfgDrive && nodeInDebug);
		if (srcWrEn) begin
			st_d.srcPin = srcWrPin;
			st_d.srcTile = srcWrTile;
		end
		// Events win over a software write in the same cycle
		if (st_d.pinEvt || tileDebugReq) begin
			st_d.srcPin = st_d.pinEvt;
			st_d.srcTile = tileDebugReq;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '{pinPrev: 1'b1, oe_n: 1'b1, default: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign debugCallTrap = st_q.callTrap;
	assign debugPinOut = 1'b0;
	assign debugPinOe_n = st_q.oe_n;
	assign srcPin = st_q.srcPin;
	assign srcTile = st_q.srcTile;
	assign pinEvent = st_q.pinEvt;
	assign tileEvent = st_q.tileEvt;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	drive_low_a: assert property (cfgDrive && nodeInDebug |=> !debugPinOe_n)
		else $error("debug pin not pulled low in debug mode");
	call_gate_a: assert property (!cfgCall |=> !debugCallTrap)
		else $error("debug call raised while disabled");
	src_pin_a: assert property (debugCallTrap |-> srcPin)
		else $error("pin event not recorded as source");
	src_tile_a: assert property (tileDebugReq && !srcWrEn |=> srcTile)
		else $error("tile event not recorded as source");
endmodule

// *** verification/swrd_fabric_model.sv ***
// Far-side model: link fabric status lines and the board side of the debug wire.
// Assumes the bench selects busy or idle fabric and may pull the wire low itself.
`timescale 1ns/1ps
module swrd_fabric_model
	import swrd_pkg::*;
#(
	parameter int NL = NUM_EXT + NUM_PLINK
)(
	// Bench control
	input  wire logic            clk,
	input  wire logic            active,
	input  wire logic            extPull,
	// Link fabric
	output logic      [NL-1:0]   linkInRoute,
	output logic      [NL-1:0]   linkOutRoute,
	output logic      [NL-1:0]   linkJunk,
	output logic      [NL*2-1:0] linkDstType,
	output logic      [NL*8-1:0] linkDstNum,
	// Debug wire
	input  wire logic            debugPinOut,
	input  wire logic            debugPinOe_n,
	output logic                 debugPinIn
);
	logic flip_q = 1'b0;

	always_ff @(posedge clk) begin
		flip_q <= ~flip_q;
	end

	always_comb begin
		for (int k = 0; k < NL; k++) begin
			linkInRoute[k] = active & k[0];
			linkOutRoute[k] = active & k[1];
			linkJunk[k] = active & k[2];
			if (linkInRoute[k]) begin
				linkDstType[2*k+:2] = 2'(k % 3);
				linkDstNum[8*k+:8] = 8'hA0 + 8'(k);
			end else begin
				// No inward route: lines carry a moving pattern, never a held value
				linkDstType[2*k+:2] = {2{flip_q}};
				linkDstNum[8*k+:8] = {8{flip_q}} ^ 8'h5A;
			end
		end
	end

	// Open drain with board pull-up
	assign debugPinIn = ~(extPull | (~debugPinOe_n & ~debugPinOut));
endmodule

// *** verification/swrd_top_tb.sv ***
// Self-checking bench for the route, debug-pin and link-status block.
// Assumes the fabric model on the far side and this bench as sole AHB-Lite master.
`timescale 1ns/1ps
module swrd_top_tb
	import swrd_pkg::*;
;
	localparam int NL = NUM_EXT + NUM_PLINK;
	logic            clk = 1'b0;
	logic            reset_n, hsel, hwrite, routeReq, nodeInDebug, tileDebugReq;
	logic            active, extPull, hreadyout, hresp, routeDone, routeLocal;
	logic            debugPinIn, debugPinOut, debugPinOe_n, debugCallTrap, irq;
	logic [31:0]     haddr, hwdata, hrdata;
	logic [1:0]      htrans;
	logic [2:0]      hsize;
	logic [15:0]     routeDestId;
	logic [3:0]      routeDir;
	logic [NL-1:0]   linkInRoute, linkOutRoute, linkJunk;
	logic [NL*2-1:0] linkDstType, linkNetwork;
	logic [NL*8-1:0] linkDstNum;
	logic [31:0]     linkDirection;
	int              nFail = 0;
	int              totalChecks = 0;

	swrd_top swrd_top_inst (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .routeReq(routeReq),
		.routeDestId(routeDestId), .routeDone(routeDone), .routeDir(routeDir),
		.routeLocal(routeLocal), .linkInRoute(linkInRoute), .linkOutRoute(linkOutRoute),
		.linkJunk(linkJunk), .linkDstType(linkDstType), .linkDstNum(linkDstNum),
		.linkDirection(linkDirection), .linkNetwork(linkNetwork), .nodeInDebug(nodeInDebug),
		.tileDebugReq(tileDebugReq), .debugPinIn(debugPinIn), .debugPinOut(debugPinOut),
		.debugPinOe_n(debugPinOe_n), .debugCallTrap(debugCallTrap), .irq(irq));
	swrd_fabric_model swrd_fabric_model_inst (.clk(clk), .active(active), .extPull(extPull),
		.linkInRoute(linkInRoute), .linkOutRoute(linkOutRoute), .linkJunk(linkJunk),
		.linkDstType(linkDstType), .linkDstNum(linkDstNum), .debugPinOut(debugPinOut),
		.debugPinOe_n(debugPinOe_n), .debugPinIn(debugPinIn));

	always #5 clk = ~clk;

	task automatic testDone;
		if (nFail == 0 && totalChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		totalChecks++;
		if (g !== e) begin
			nFail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		chk32(nm, {31'h0, e}, {31'h0, g});
	endtask

	// Outputs are read as sampled at the edge, before that edge's updates land
	task automatic waitRdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			nFail++;
			testDone();
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		waitRdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		waitRdy();
		r = hrdata;
		chk1("hresp", 1'b0, hresp);
	endtask

	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, {22'h0, i, 2'h0}, d, r);
	endtask

	task automatic rdChk(input logic [7:0] i, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, {22'h0, i, 2'h0}, 32'h0, r);
		chk32($sformatf("reg %h", i), e, r);
	endtask

	task automatic doReset;
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
	endtask

	task automatic tReset;
		rdChk(IDX_NODE_ID, WORD_RST);
		rdChk(IDX_DIR_HI, WORD_RST);
		rdChk(IDX_DIR_LO, WORD_RST);
		rdChk(IDX_DBG_CFG, WORD_RST);
		rdChk(IDX_EXT_BASE, WORD_RST);
		rdChk(IDX_PL_BASE + 8'h03, WORD_RST);
		chk32("linkDirection", 32'h0, linkDirection);
		chk32("linkNetwork", 32'h0, 32'(linkNetwork));
		chk1("oe", 1'b1, debugPinOe_n);
		chk1("pin out", 1'b0, debugPinOut);
	endtask

	task automatic tUnmapped;
		logic [31:0] r;
		wr(IDX_NODE_ID, 32'h0000_00C3);
		ahb(1'b1, 32'h0000_0414, 32'h0000_FFFF, r);
		ahb(1'b0, 32'h0000_0414, 32'h0, r);
		chk32("alias read", 32'h0, r);
		rdChk(IDX_NODE_ID, 32'h0000_00C3);
	endtask

	task automatic tRoute;
		logic [15:0] d;
		wr(IDX_NODE_ID, 32'hFFFF_A5C3);
		rdChk(IDX_NODE_ID, 32'h0000_A5C3);
		wr(IDX_DIR_HI, 32'hFEDC_BA98);
		rdChk(IDX_DIR_HI, 32'hFEDC_BA98);
		wr(IDX_DIR_LO, 32'h7654_3210);
		// Flipping the lower bits too shows that only the top mismatch counts
		for (int b = 0; b <= 16; b++) begin
			d = (b == 16) ? 16'hA5C3 : 16'hA5C3 ^ 16'((32'h2 << b) - 1);
			routeReq <= 1'b1;
			routeDestId <= d;
			@(posedge clk);
			routeReq <= 1'b0;
			@(posedge clk);
			chk1("routeDone", 1'b1, routeDone);
			chk32("routeDir", (b == 16) ? 32'h0 : 32'(b), 32'(routeDir));
			chk1("routeLocal", b == 16, routeLocal);
		end
	endtask

	task automatic tLinks;
		logic [7:0] i;
		logic [31:0] e;
		active <= 1'b1;
		for (int k = 0; k < NL; k++) begin
			i = (k < 8) ? IDX_EXT_BASE + 8'(k) : IDX_PL_BASE + 8'(k - 8);
			wr(i, {20'hFFFFF, 4'(15 - k), 2'h3, 2'(k + 1), 4'hF});
			e = k[0] ? {6'h0, 2'(k % 3), 8'hA0 + 8'(k), 16'h0} : 32'h0;
			e = e | {20'h0, (k < 8) ? 4'(15 - k) : 4'h0, 2'h0, 2'(k + 1), 1'b0, 3'(k)};
			rdChk(i, e);
			chk32("linkNetwork", 32'(k + 1) & 32'h3, 32'(linkNetwork[2*k+:2]));
			if (k < 8) begin
				chk32("linkDirection", 32'(15 - k), 32'(linkDirection[4*k+:4]));
			end
		end
		rdChk(IDX_IRQ_STAT, 32'h4);
		chk1("irq masked", 1'b0, irq);
		wr(IDX_IRQ_STAT, 32'h4);
		active <= 1'b0;
	endtask

	task automatic pullPin(input logic ext, input logic [31:0] hits);
		int n;
		n = 0;
		extPull <= ext;
		repeat (4) begin
			@(posedge clk);
			n += int'(debugCallTrap === 1'b1);
		end
		extPull <= 1'b0;
		chk32("trap pulses", hits, 32'(n));
	endtask

	task automatic tDebug;
		wr(IDX_IRQ_MASK, 32'h7);
		wr(IDX_DBG_SRC, 32'h0);
		wr(IDX_DBG_CFG, 32'hFFFF_FFFE);
		rdChk(IDX_DBG_CFG, 32'h2);
		pullPin(1'b1, 32'h1);
		rdChk(IDX_DBG_SRC, 32'h10);
		chk1("irq", 1'b1, irq);
		wr(IDX_IRQ_STAT, 32'h1);
		rdChk(IDX_IRQ_STAT, 32'h0);
		chk1("irq", 1'b0, irq);
		wr(IDX_DBG_CFG, 32'h0);
		pullPin(1'b1, 32'h0);
		wr(IDX_DBG_SRC, 32'h0);
		wr(IDX_IRQ_MASK, 32'h5);
		tileDebugReq <= 1'b1;
		@(posedge clk);
		tileDebugReq <= 1'b0;
		rdChk(IDX_DBG_SRC, 32'h1);
		chk1("irq masked", 1'b0, irq);
		wr(IDX_IRQ_MASK, 32'h7);
		rdChk(IDX_IRQ_STAT, 32'h2);
		chk1("irq", 1'b1, irq);
		wr(IDX_IRQ_STAT, 32'h2);
		wr(IDX_DBG_SRC, 32'hFFFF_FFFF);
		rdChk(IDX_DBG_SRC, 32'h11);
	endtask

	task automatic tDrive;
		for (int c = 0; c < 4; c++) begin
			wr(IDX_DBG_CFG, 32'(c));
			nodeInDebug <= 1'b1;
			// Own drive must not count as a request from outside
			pullPin(1'b0, 32'h0);
			chk1("oe", !c[0], debugPinOe_n);
			nodeInDebug <= 1'b0;
			repeat (2) @(posedge clk);
			chk1("oe idle", 1'b1, debugPinOe_n);
		end
	endtask

	initial begin
		{hsel, hwrite, routeReq, nodeInDebug, tileDebugReq, active, extPull} = '0;
		reset_n = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		routeDestId = 16'h0;
		doReset();
		tReset();
		tUnmapped();
		tRoute();
		tLinks();
		tDebug();
		tDrive();
		doReset();
		rdChk(IDX_NODE_ID, WORD_RST);
		testDone();
	end
endmodule
